// File: rtl/dcv_bank.sv
/*
  configuration variable bank of the locomotive decoder: storage, range
  checks, factory restore, fault memory, and the settings it drives.
  assumes accesses arrive one per cycle from packet decoding logic on clk.
*/
`include "dcv_cfg.svh"

module dcv_bank
  import dcv_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // variable access from packet decoding
  input  wire dcv_cv_req_t req,
  output logic       [7:0] rd_data_q,
  output logic             rd_valid_q,
  // decoder state from same-clock logic
  input  wire logic  [7:0] speed_step,
  input  wire logic        light_req,
  // pins: motor short, light short, analog voltage, brake signal
  input  wire logic  [3:0] pins,
  // settings and derived outputs
  output dcv_ctl_t         ctl_q,
  output logic             light_q,
  output logic             brake_q,
  output logic             reg_tick_q,
  output logic             measure_q
);

  logic [7:0]  opt_q;
  logic [7:0]  bright_q;
  logic [7:0]  mode_q;
  logic [7:0]  rate_q;
  logic [7:0]  motor_q;
  logic [7:0]  slot_q;
  logic [7:0]  fact_q;
  logic [7:0]  short_q;
  logic [7:0]  offset_q;
  logic [7:0]  page_q;
  logic [7:0]  fault_q;
  logic [7:0]  train_q;
  logic [3:0]  pin_lv;
  logic [3:0]  pin_prev_q;
  logic [9:0]  eff;
  logic        prog_ok;
  logic        wr_ok;
  logic        restore;
  logic        mot_rise;
  logic        lgt_rise;
  logic [4:0]  pwm_q;
  logic [11:0] unit_q;
  logic        unit_tick;
  logic [8:0]  ph_q;
  logic [8:0]  period;
  dcv_reg_st_t st_q;

  // effective variable number; offset reaches beyond direct numbering
  function automatic logic [9:0] eff_num(input dcv_cv_req_t r,
                                         input logic [7:0] ofs);
    if (r.src_dcc || r.num == `DCV_CV_OFFSET || r.num == `DCV_CV_PAGE)
      eff_num = r.num;
    else
      eff_num = r.num + {2'h0, ofs};
  endfunction

  // documented value range per variable
  function automatic logic in_range(input logic [9:0] n,
                                    input logic [7:0] v);
    case (n)
      `DCV_CV_LIGHT: in_range = v <= `DCV_LIGHT_MAX;
      `DCV_CV_MODE:  in_range = v <= `DCV_MODE_MAX;
      `DCV_CV_MOTOR: in_range = v[1:0] != `DCV_MOTOR_BAD;
      `DCV_CV_FACT:  in_range = v <= `DCV_FACT_GO;
      `DCV_CV_SHORT: in_range = v == `DCV_SHORT_OFF || v == `DCV_SHORT_ON;
      `DCV_CV_FAULT: in_range = v <= `DCV_FAULT_LGT;
      `DCV_CV_TRAIN: in_range = v >= `DCV_TRAIN_MIN && v <= `DCV_TRAIN_MAX;
      default:       in_range = 1'b1;
    endcase
  endfunction

  dcv_pin_filter #(
    .W(4)
  ) u_pins (
    .clk    (clk),
    .reset  (reset),
    .pin    (pins),
    .level_q(pin_lv)
  );

  assign eff     = eff_num(req, offset_q);
  assign prog_ok = req.src_dcc | ~(opt_q[`DCV_OPT_DCC_ONLY] |
                                   opt_q[`DCV_OPT_ALT_ONLY]);
  assign wr_ok   = req.wr & prog_ok & in_range(eff, req.data);
  assign restore = wr_ok && eff == `DCV_CV_FACT &&
                   req.data == `DCV_FACT_GO;

  // variable storage; restore wins over any stored value
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      opt_q    <= `DCV_RST_OPT;
      bright_q <= `DCV_RST_LIGHT;
      mode_q   <= `DCV_RST_MODE;
      rate_q   <= `DCV_RST_RATE;
      motor_q  <= `DCV_RST_MOTOR;
      slot_q   <= `DCV_RST_SLOT;
      fact_q   <= `DCV_RST_FACT;
      short_q  <= `DCV_RST_SHORT;
      offset_q <= `DCV_RST_OFFSET;
      page_q   <= `DCV_RST_PAGE;
      train_q  <= `DCV_RST_TRAIN;
    end else if (restore) begin
      opt_q    <= `DCV_RST_OPT;
      bright_q <= `DCV_RST_LIGHT;
      mode_q   <= `DCV_RST_MODE;
      rate_q   <= `DCV_RST_RATE;
      motor_q  <= `DCV_RST_MOTOR;
      slot_q   <= `DCV_RST_SLOT;
      fact_q   <= `DCV_RST_FACT;
      short_q  <= `DCV_RST_SHORT;
      offset_q <= `DCV_RST_OFFSET;
      page_q   <= `DCV_RST_PAGE;
      train_q  <= `DCV_RST_TRAIN;
    end else if (wr_ok) begin
      case (eff)
        `DCV_CV_OPT:    opt_q    <= req.data;
        `DCV_CV_LIGHT:  bright_q <= req.data;
        `DCV_CV_MODE:   mode_q   <= req.data;
        `DCV_CV_RATE:   rate_q   <= req.data;
        `DCV_CV_MOTOR:  motor_q  <= req.data;
        `DCV_CV_SLOT:   slot_q   <= req.data;
        `DCV_CV_SHORT:  short_q  <= req.data;
        `DCV_CV_OFFSET: offset_q <= req.data;
        `DCV_CV_PAGE:   page_q   <= req.data;
        `DCV_CV_TRAIN:  train_q  <= req.data;
        default: ;
      endcase
    end
  end

  // fault memory: a new short wins over a clearing write
  assign mot_rise = pin_lv[`DCV_PIN_MSHORT] & ~pin_prev_q[`DCV_PIN_MSHORT];
  assign lgt_rise = pin_lv[`DCV_PIN_LSHORT] & ~pin_prev_q[`DCV_PIN_LSHORT];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_prev_q <= '0;
      fault_q    <= `DCV_RST_FAULT;
    end else begin
      pin_prev_q <= pin_lv;
      if (mot_rise)
        fault_q <= `DCV_FAULT_MOT;
      else if (lgt_rise)
        fault_q <= `DCV_FAULT_LGT;
      else if (restore)
        fault_q <= `DCV_RST_FAULT;
      else if (wr_ok && eff == `DCV_CV_FAULT)
        fault_q <= req.data;
    end
  end

  // read back; refused reads answer zero so the station sees no ack value
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data_q  <= '0;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= req.rd & prog_ok;
      rd_data_q  <= '0;
      if (req.rd && prog_ok) begin
        case (eff)
          `DCV_CV_OPT:    rd_data_q <= opt_q;
          `DCV_CV_LIGHT:  rd_data_q <= bright_q;
          `DCV_CV_MODE:   rd_data_q <= mode_q;
          `DCV_CV_RATE:   rd_data_q <= rate_q;
          `DCV_CV_MOTOR:  rd_data_q <= motor_q;
          `DCV_CV_SLOT:   rd_data_q <= slot_q;
          `DCV_CV_FACT:   rd_data_q <= fact_q;
          `DCV_CV_SHORT:  rd_data_q <= short_q;
          `DCV_CV_OFFSET: rd_data_q <= offset_q;
          `DCV_CV_PAGE:   rd_data_q <= page_q;
          `DCV_CV_FAULT:  rd_data_q <= fault_q;
          `DCV_CV_TRAIN:  rd_data_q <= train_q;
          default:        rd_data_q <= '0;
        endcase
      end
    end
  end

  // settings applied to the decoder
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl_q <= '0;
    end else begin
      ctl_q.dcc_ok <= ~opt_q[`DCV_OPT_ALT_ONLY] &
                      mode_q != `DCV_MODE_ANA;
      ctl_q.alt_ok <= ~opt_q[`DCV_OPT_DCC_ONLY] &
                      mode_q != `DCV_MODE_ANA;
      ctl_q.analog_en <= ~opt_q[`DCV_OPT_DIG_ONLY] &
                         mode_q != `DCV_MODE_DIG;
      ctl_q.brake_analog   <= opt_q[`DCV_OPT_BRAKE_ANA];
      ctl_q.short_prot_en  <= short_q == `DCV_SHORT_ON;
      ctl_q.speed_dep_rate <= motor_q[`DCV_MOT_SPEED_DEP];
      ctl_q.motor_volt     <= motor_q[1:0];
      ctl_q.op_mode        <= mode_q[1:0];
    end
  end

  // brake: dedicated signal always, analog voltage only when enabled
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      brake_q <= 1'b0;
    else
      brake_q <= pin_lv[`DCV_PIN_BRAKE] |
                 (opt_q[`DCV_OPT_BRAKE_ANA] & pin_lv[`DCV_PIN_ANALOG]);
  end

  // light pwm over 31 slots so that 31 means always on
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwm_q   <= '0;
      light_q <= 1'b0;
    end else begin
      pwm_q   <= (pwm_q == 5'h1e) ? 5'h00 : pwm_q + 5'h01;
      light_q <= light_req && bright_q[4:0] > pwm_q;
    end
  end

  // rate unit prescaler
  assign unit_tick = unit_q == 12'(`DCV_REG_UNIT_CYC - 1);

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      unit_q <= '0;
    else
      unit_q <= unit_tick ? 12'h000 : unit_q + 12'h001;
  end

  // slow running stretches the period; a trade of response for smoothness
  assign period = motor_q[`DCV_MOT_SPEED_DEP] ?
                  {1'b0, rate_q} + {4'h0, ~speed_step[7:3]} :
                  {1'b0, rate_q};

  // measure slot, then run phase, then one regulation tick
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q       <= DCV_ST_MEAS;
      ph_q       <= '0;
      measure_q  <= 1'b0;
      reg_tick_q <= 1'b0;
    end else begin
      reg_tick_q <= 1'b0;
      case (st_q)
        DCV_ST_MEAS: begin
          measure_q <= slot_q != 8'h00 && ph_q < {1'b0, slot_q};
          if ({1'b0, slot_q} <= ph_q) begin
            st_q <= DCV_ST_RUN;
            ph_q <= '0;
          end else if (unit_tick) begin
            ph_q <= ph_q + 9'h001;
          end
        end
        DCV_ST_RUN: begin
          measure_q <= 1'b0;
          if (unit_tick) begin
            if (ph_q >= period) begin
              reg_tick_q <= 1'b1;
              st_q       <= DCV_ST_MEAS;
              ph_q       <= '0;
            end else begin
              ph_q <= ph_q + 9'h001;
            end
          end
        end
        default: begin
          st_q <= DCV_ST_MEAS;
          ph_q <= '0;
        end
      endcase
    end
  end

  property p_dcc_only;
    @(posedge clk) disable iff (reset)
      opt_q[`DCV_OPT_DCC_ONLY] |=> !ctl_q.alt_ok;
  endproperty
  a_dcc_only: assert property (p_dcc_only)
    else $error("alternate format accepted in dcc-only mode");

  property p_alt_only;
    @(posedge clk) disable iff (reset)
      opt_q[`DCV_OPT_ALT_ONLY] |=> !ctl_q.dcc_ok;
  endproperty
  a_alt_only: assert property (p_alt_only)
    else $error("dcc accepted in alternate-only mode");

  property p_dig_only;
    @(posedge clk) disable iff (reset)
      opt_q[`DCV_OPT_DIG_ONLY] || mode_q == `DCV_MODE_DIG
      |=> !ctl_q.analog_en;
  endproperty
  a_dig_only: assert property (p_dig_only)
    else $error("analog recognition left on");

  property p_brake_analog;
    @(posedge clk) disable iff (reset)
      opt_q[`DCV_OPT_BRAKE_ANA] && pin_lv[`DCV_PIN_ANALOG] |=> brake_q;
  endproperty
  a_brake_analog: assert property (p_brake_analog)
    else $error("no brake on analog voltage");

  property p_light_off;
    @(posedge clk) disable iff (reset)
      bright_q == 8'h00 |=> !light_q;
  endproperty
  a_light_off: assert property (p_light_off)
    else $error("light on at brightness zero");

  property p_light_full;
    @(posedge clk) disable iff (reset)
      (bright_q == `DCV_LIGHT_MAX && light_req)[*2] |=> light_q;
  endproperty
  a_light_full: assert property (p_light_full)
    else $error("light not full at brightness 31");

  property p_analog_mode;
    @(posedge clk) disable iff (reset)
      mode_q == `DCV_MODE_ANA |=> !ctl_q.dcc_ok && !ctl_q.alt_ok;
  endproperty
  a_analog_mode: assert property (p_analog_mode)
    else $error("digital accepted in analog-only mode");

  property p_restore;
    @(posedge clk) disable iff (reset)
      restore |=> bright_q == `DCV_RST_LIGHT && short_q == `DCV_RST_SHORT
                  && fact_q == `DCV_RST_FACT && offset_q == `DCV_RST_OFFSET;
  endproperty
  a_restore: assert property (p_restore)
    else $error("factory restore incomplete");

  property p_range;
    @(posedge clk) disable iff (reset)
      req.wr && eff == `DCV_CV_LIGHT && req.data > `DCV_LIGHT_MAX
      |=> $stable(bright_q);
  endproperty
  a_range: assert property (p_range)
    else $error("out-of-range write stored");

  property p_prog_src;
    @(posedge clk) disable iff (reset)
      req.wr && !req.src_dcc && (opt_q[`DCV_OPT_DCC_ONLY] ||
      opt_q[`DCV_OPT_ALT_ONLY]) |=> $stable(offset_q) && $stable(page_q)
      && $stable(bright_q);
  endproperty
  a_prog_src: assert property (p_prog_src)
    else $error("non-dcc programming taken while restricted");

  property p_fault;
    @(posedge clk) disable iff (reset)
      mot_rise |=> fault_q == `DCV_FAULT_MOT;
  endproperty
  a_fault: assert property (p_fault)
    else $error("motor short not recorded");

  property p_short;
    @(posedge clk) disable iff (reset)
      short_q == `DCV_SHORT_OFF |=> !ctl_q.short_prot_en;
  endproperty
  a_short: assert property (p_short)
    else $error("short protection on with guard zero");

  property p_slot;
    @(posedge clk) disable iff (reset)
      reg_tick_q && slot_q != 8'h00 |=> measure_q;
  endproperty
  a_slot: assert property (p_slot)
    else $error("measurement slot missing after tick");

  c_restore: cover property (@(posedge clk) disable iff (reset) restore);
  c_tick: cover property (@(posedge clk) disable iff (reset) reg_tick_q);
  c_light: cover property (@(posedge clk) disable iff (reset) lgt_rise);

endmodule

// File: rtl/dcv_cfg.svh
/*
  constants of the decoder configuration bank: variable numbers, factory
  values, flag positions and timing. assumes a 50 MHz decoder clock.
*/
`ifndef DCV_CFG_SVH
`define DCV_CFG_SVH

// variable numbers as seen on the programming track
`define DCV_CV_OPT     10'h031
`define DCV_CV_LIGHT   10'h032
`define DCV_CV_MODE    10'h033
`define DCV_CV_RATE    10'h035
`define DCV_CV_MOTOR   10'h036
`define DCV_CV_SLOT    10'h03a
`define DCV_CV_FACT    10'h03b
`define DCV_CV_SHORT   10'h03c
`define DCV_CV_OFFSET  10'h041
`define DCV_CV_PAGE    10'h042
`define DCV_CV_FAULT   10'h064
`define DCV_CV_TRAIN   10'h073

// factory values
`define DCV_RST_OPT    8'h00
`define DCV_RST_LIGHT  8'h10
`define DCV_RST_MODE   8'h03
`define DCV_RST_RATE   8'h28
`define DCV_RST_MOTOR  8'h84
`define DCV_RST_SLOT   8'h08
`define DCV_RST_FACT   8'h00
`define DCV_RST_SHORT  8'h23
`define DCV_RST_OFFSET 8'h00
`define DCV_RST_PAGE   8'h00
`define DCV_RST_FAULT  8'h00
`define DCV_RST_TRAIN  8'h01

// option and motor flag positions
`define DCV_OPT_DCC_ONLY   3
`define DCV_OPT_ALT_ONLY   4
`define DCV_OPT_DIG_ONLY   6
`define DCV_OPT_BRAKE_ANA  7
`define DCV_MOT_SPEED_DEP  2

// value limits and codes
`define DCV_LIGHT_MAX  8'h1f
`define DCV_MODE_DIG   8'h01
`define DCV_MODE_ANA   8'h02
`define DCV_MODE_MAX   8'h03
`define DCV_FACT_GO    8'h01
`define DCV_SHORT_ON   8'h23
`define DCV_SHORT_OFF  8'h00
`define DCV_FAULT_NONE 8'h00
`define DCV_FAULT_MOT  8'h01
`define DCV_FAULT_LGT  8'h02
`define DCV_TRAIN_MIN  8'h01
`define DCV_TRAIN_MAX  8'h04
`define DCV_MOTOR_BAD  2'h2

// pin bit positions
`define DCV_PIN_MSHORT 0
`define DCV_PIN_LSHORT 1
`define DCV_PIN_ANALOG 2
`define DCV_PIN_BRAKE  3

// timing: one regulation rate unit is 50 us
`define DCV_CLK_NS       20
`define DCV_REG_UNIT_NS  50000
`define DCV_REG_UNIT_CYC (`DCV_REG_UNIT_NS / `DCV_CLK_NS)

`endif

// File: rtl/dcv_pkg.sv
/*
  types of the decoder configuration bank.
  assumes dcv_cfg.svh is compiled before it.
*/
package dcv_pkg;

  // one access from the track packet decoder
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       src_dcc;
    logic [9:0] num;
    logic [7:0] data;
  } dcv_cv_req_t;

  // settings applied to the rest of the decoder
  typedef struct packed {
    logic       dcc_ok;
    logic       alt_ok;
    logic       analog_en;
    logic       brake_analog;
    logic       short_prot_en;
    logic       speed_dep_rate;
    logic [1:0] motor_volt;
    logic [1:0] op_mode;
  } dcv_ctl_t;

  typedef enum logic [1:0] {
    DCV_ST_MEAS = 2'b00,
    DCV_ST_RUN  = 2'b01
  } dcv_reg_st_t;

endpackage

// File: rtl/dcv_pin_filter.sv
/*
  three-stage pin synchroniser with agreement filter.
  assumes asynchronous pins; output is a level in the clk domain.
*/
`include "dcv_cfg.svh"

module dcv_pin_filter
  import dcv_pkg::*;
#(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // pins and filtered levels
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level_q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_d;

  // a change counts once stages two and three agree
  assign level_d = (s2_q & s3_q) | (level_q & (s2_q ^ s3_q));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      level_q <= '0;
    end else begin
      s1_q    <= pin;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end

endmodule

// File: testbench/dcv_station.sv
/*
  command station model: issues variable writes and reads to the bank.
  assumes the bank samples req on the rising clk edge, one access at a time.
*/
`include "dcv_cfg.svh"

module dcv_station
  import dcv_pkg::*;
(
  // clock
  input  wire logic        clk,
  // variable access
  output dcv_cv_req_t      req,
  input  wire logic  [7:0] rd_data_q,
  input  wire logic        rd_valid_q
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  // idle lines carry inverted junk so a stale value is never mistaken
  task automatic wr(input logic s, input logic [9:0] n, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (n == `DCV_CV_MOTOR) v[7:3] = 5'h10;
    @(posedge clk);
    req <= '{1'b1, 1'b0, s, n, v};
    @(posedge clk);
    req <= '{1'b0, 1'b0, s, ~n, ~v};
  endtask

  task automatic rd(input logic s, input logic [9:0] n,
                    output logic [7:0] d, output logic ok);
    @(posedge clk);
    req <= '{1'b0, 1'b1, s, n, 8'h00};
    @(posedge clk);
    req <= '{1'b0, 1'b0, s, ~n, 8'hff};
    #1;
    ok = rd_valid_q;
    d = rd_data_q;
  endtask
endmodule

// File: testbench/tb.sv
/*
  self-checking bench of the configuration bank.
  assumes a 50 MHz clock and the command station model beside the bank.
*/
`include "dcv_cfg.svh"

module tb
  import dcv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        reset;
  dcv_cv_req_t req;
  logic  [7:0] rd_data_q;
  logic        rd_valid_q;
  logic  [7:0] speed_step;
  logic        light_req;
  logic  [3:0] pins;
  dcv_ctl_t    ctl_q;
  logic        light_q;
  logic        brake_q;
  logic        reg_tick_q;
  logic        measure_q;
  int          miscompares = 0;
  int          num_checks = 0;

  dcv_bank u_dut (.clk(clk), .reset(reset), .req(req),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .speed_step(speed_step), .light_req(light_req), .pins(pins),
    .ctl_q(ctl_q), .light_q(light_q), .brake_q(brake_q),
    .reg_tick_q(reg_tick_q), .measure_q(measure_q));

  dcv_station st (.clk(clk), .req(req), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic rchk(input logic s, input logic [9:0] n, input logic [8:0] e);
    logic [7:0] d;
    logic ok;
    st.rd(s, n, d, ok);
    chk({1'b0, ok, d}, {1'b0, e});
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    logic [9:0] n [12] = '{`DCV_CV_OPT, `DCV_CV_LIGHT, `DCV_CV_MODE,
      `DCV_CV_RATE, `DCV_CV_MOTOR, `DCV_CV_SLOT, `DCV_CV_FACT,
      `DCV_CV_SHORT, `DCV_CV_OFFSET, `DCV_CV_PAGE, `DCV_CV_FAULT,
      `DCV_CV_TRAIN};
    logic [7:0] e [12] = '{`DCV_RST_OPT, `DCV_RST_LIGHT, `DCV_RST_MODE,
      `DCV_RST_RATE, `DCV_RST_MOTOR, `DCV_RST_SLOT, `DCV_RST_FACT,
      `DCV_RST_SHORT, `DCV_RST_OFFSET, `DCV_RST_PAGE, `DCV_RST_FAULT,
      `DCV_RST_TRAIN};
    #1;
    chk(ctl_q, 10'h3b3);
    for (int i = 0; i < 12; i++) begin
      rchk(1'b1, n[i], {1'b1, e[i]});
    end
    rchk(1'b1, 10'h3ff, 9'h100);
  endtask

  task automatic span(output int per, output int meas);
    per = 0;
    meas = 0;
    do begin
      @(posedge clk);
      #1;
      per++;
      meas += int'(measure_q === 1'b1);
    end while (reg_tick_q !== 1'b1 && per < 40000);
  endtask

  // long default period: shrink slot and rate so one period is 2 units
  task automatic t_regtick();
    int per, meas;
    st.wr(1'b1, `DCV_CV_SLOT, 8'h01);
    st.wr(1'b1, `DCV_CV_RATE, 8'h00);
    st.wr(1'b1, `DCV_CV_MOTOR, 8'h80);
    span(per, meas);
    span(per, meas);
    chk(10'(per >= 4998 && per <= 5002), 10'h1);
    chk(10'(meas >= 2498 && meas <= 2502), 10'h1);
    st.wr(1'b1, `DCV_CV_MOTOR, 8'h84);
    speed_step <= 8'hf0;
    span(per, meas);
    span(per, meas);
    chk(10'(per >= 7498 && per <= 7502), 10'h1);
  endtask

  task automatic t_options();
    logic [7:0] o [4] = '{8'h08, 8'h10, 8'h40, 8'h80};
    logic [3:0] e [4] = '{4'b1010, 4'b0110, 4'b1100, 4'b1111};
    for (int i = 0; i < 4; i++) begin
      st.wr(1'b1, `DCV_CV_OPT, o[i]);
      settle();
      chk(ctl_q[9:6], e[i]);
      if (i < 2) begin
        st.wr(1'b0, `DCV_CV_LIGHT, 8'h05);
        rchk(1'b0, `DCV_CV_LIGHT, 9'h000);
        rchk(1'b1, `DCV_CV_LIGHT, 9'h110);
      end
    end
    st.wr(1'b1, `DCV_CV_OPT, 8'h00);
  endtask

  task automatic t_mode();
    logic [2:0] e [3] = '{3'b110, 3'b001, 3'b111};
    for (int m = 1; m < 4; m++) begin
      st.wr(1'b1, `DCV_CV_MODE, 8'(m));
      settle();
      chk({ctl_q[9:7], ctl_q[1:0]}, {e[m-1], 2'(m)});
    end
    st.wr(1'b1, `DCV_CV_MODE, 8'h04);
    rchk(1'b1, `DCV_CV_MODE, 9'h103);
  endtask

  task automatic t_motor();
    logic [7:0] v [3] = '{8'h80, 8'h81, 8'h83};
    for (int i = 0; i < 3; i++) begin
      st.wr(1'b1, `DCV_CV_MOTOR, v[i]);
      settle();
      chk(ctl_q[4:2], {1'b0, v[i][1:0]});
    end
    st.wr(1'b1, `DCV_CV_MOTOR, 8'h82);
    rchk(1'b1, `DCV_CV_MOTOR, 9'h183);
    st.wr(1'b1, `DCV_CV_MOTOR, 8'h84);
    settle();
    chk(ctl_q[4:2], 3'b100);
  endtask

  task automatic t_ranges();
    logic [9:0] n [3] = '{`DCV_CV_LIGHT, `DCV_CV_SHORT, `DCV_CV_TRAIN};
    logic [7:0] g [3] = '{8'h1f, 8'h00, 8'h04};
    logic [7:0] b [3] = '{8'h20, 8'h07, 8'h05};
    for (int i = 0; i < 3; i++) begin
      st.wr(1'b1, n[i], g[i]);
      st.wr(1'b1, n[i], b[i]);
      rchk(1'b1, n[i], {1'b1, g[i]});
    end
    settle();
    chk(ctl_q[5], 1'b0);
    st.wr(1'b1, `DCV_CV_SHORT, 8'h23);
    settle();
    chk(ctl_q[5], 1'b1);
    st.wr(1'b1, `DCV_CV_FACT, 8'h02);
    st.wr(1'b1, `DCV_CV_FAULT, 8'h03);
    rchk(1'b1, `DCV_CV_FACT, 9'h100);
    rchk(1'b1, `DCV_CV_FAULT, 9'h100);
    st.wr(1'b1, `DCV_CV_OFFSET, 8'h05);
    st.wr(1'b1, `DCV_CV_PAGE, 8'hff);
    rchk(1'b1, `DCV_CV_OFFSET, 9'h105);
    rchk(1'b1, `DCV_CV_PAGE, 9'h1ff);
    st.wr(1'b0, `DCV_CV_LIGHT - 10'h005, 8'h09);
    rchk(1'b0, `DCV_CV_LIGHT - 10'h005, 9'h109);
    rchk(1'b1, `DCV_CV_LIGHT, 9'h109);
  endtask

  task automatic t_light();
    logic [7:0] v [3] = '{8'h00, 8'h1f, 8'h10};
    logic [9:0] e [3] = '{10'h000, 10'h03e, 10'h020};
    int hi;
    @(posedge clk);
    light_req <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      st.wr(1'b1, `DCV_CV_LIGHT, v[k]);
      repeat (40) @(posedge clk);
      hi = 0;
      repeat (62) begin
        @(posedge clk);
        #1;
        hi += int'(light_q === 1'b1);
      end
      chk(10'(hi), e[k]);
    end
  endtask

  task automatic t_fault();
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      pins <= 4'(1 << k);
      repeat (12) @(posedge clk);
      pins <= 4'h0;
      repeat (8) @(posedge clk);
      rchk(1'b1, `DCV_CV_FAULT, 9'(9'h101 + k));
      st.wr(1'b1, `DCV_CV_FAULT, 8'h00);
      rchk(1'b1, `DCV_CV_FAULT, 9'h100);
    end
    @(posedge clk);
    pins <= 4'h8;
    repeat (10) @(posedge clk);
    #1;
    chk(brake_q, 1'b1);
    @(posedge clk);
    pins <= 4'h4;
    repeat (10) @(posedge clk);
    #1;
    chk(brake_q, 1'b0);
    st.wr(1'b1, `DCV_CV_OPT, 8'h80);
    settle();
    chk(brake_q, 1'b1);
    st.wr(1'b1, `DCV_CV_OPT, 8'h00);
    pins <= 4'h0;
  endtask

  task automatic t_restore();
    st.wr(1'b1, `DCV_CV_LIGHT, 8'h05);
    st.wr(1'b1, `DCV_CV_RATE, 8'h07);
    st.wr(1'b1, `DCV_CV_FACT, 8'h01);
    settle();
    rchk(1'b1, `DCV_CV_LIGHT, 9'h110);
    rchk(1'b1, `DCV_CV_RATE, 9'h128);
    rchk(1'b1, `DCV_CV_FACT, 9'h100);
    rchk(1'b1, `DCV_CV_OFFSET, 9'h100);
  endtask

  initial begin
    reset = 1'b1;
    speed_step = 8'h10;
    light_req = 1'b0;
    pins = 4'h0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regtick();
    t_options();
    t_mode();
    t_motor();
    t_ranges();
    t_light();
    t_fault();
    t_restore();
    give_verdict();
  end

  // a full run needs about 26k cycles
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule
